// ===== hdl/sar_converter_pkg.sv
// constants for the converter control block: register map, fields, states
// Contract
// - status write clears flag, starts conversion
// - flag bit 7 set per conversion
// - result byte read clears flag
// - flag not writable by software
// - interrupt on completion when enabled
// - interrupt level follows the flag
// - reset clears pending interrupt
// - continuous mode converts back to back
// - single mode: one conversion per write
// - channel codes route to pins, references
// - reserved codes select low reference
// - divide bus clock by 2*(prescale+1)
// - signed only when left justified
// - eight-bit result always in high byte
// - eight-bit unsigned: FF/00 and 00/00
// - ten-bit signed left: 7F/C0 and 80/00
// - ten-bit right: 03/FF and 00/00
// - left and right bit mapping
// - signed by inverting result msb
// - general control write aborts only
// - power-up clear aborts, resets low
package sar_converter_pkg;
	// apb byte addresses of the registers
	localparam logic [7:0] GEN_CTRL_ADDR    = 8'h00;
	localparam logic [7:0] STAT_CTRL_ADDR   = 8'h04;
	localparam logic [7:0] RESULT_HIGH_ADDR = 8'h08;
	localparam logic [7:0] RESULT_LOW_ADDR  = 8'h0C;
	// general control fields
	localparam int POWER_UP_BIT  = 7;
	localparam int JUSTIFY_BIT   = 6;
	localparam int EIGHT_BIT_BIT = 5;
	localparam int SIGNED_BIT    = 4;
	localparam int PRESCALE_MSB  = 3;
	// status and control fields
	localparam int DONE_FLAG_BIT = 7;
	localparam int IRQ_EN_BIT    = 6;
	localparam int CONT_BIT      = 5;
	localparam int CHANNEL_MSB   = 4;
	// reset values
	localparam logic [7:0] GEN_CTRL_RESET  = 8'h00;
	localparam logic [6:0] STAT_CTRL_RESET = 7'h00;
	// channel codes
	localparam int          NUM_INPUTS   = 8;
	localparam logic [4:0]  CH_HIGH_REF  = 5'h1E;
	localparam logic [4:0]  CH_LOW_REF   = 5'h1F;
	// prescaler counter width (factor up to 32)
	localparam int          PRE_W        = 5;
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b01,
		ST_CONVERT = 2'b10
	} conv_state_t;
endpackage : sar_converter_pkg

// ===== hdl/sar_converter_control.sv
// converter control: apb registers, sequencing, prescaler, result format
`timescale 1ns/1ps
module sar_converter_control (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// sar core side
	input  wire logic        sar_done,
	input  wire logic [9:0]  sar_result,
	output logic             conv_start,
	output logic             conv_clk_en,
	output logic             converter_power_up,
	output logic [7:0]       analog_input_sel,
	output logic             high_reference_sel,
	output logic             low_reference_sel,
	// interrupt request
	output logic             done_irq
);
	// register state
	logic [7:0]  gen_q, gen_d;            // general control
	logic [6:0]  sc_q, sc_d;              // status control writable bits
	logic        flag_q, flag_d;          // conversion done flag
	logic [9:0]  raw_q, raw_d;            // latched raw result
	logic        irq_q, irq_d;            // interrupt output flop
	// apb state
	logic        ready_q, ready_d;
	logic        err_q, err_d;
	logic [31:0] rdata_q, rdata_d;
	// prescaler counter width, declared ahead of its first use
	localparam int PRE_W_L = sar_converter_pkg::PRE_W;
	// sequencer state
	sar_converter_pkg::conv_state_t state_q, state_d;
	logic        start_q, start_d;
	logic [PRE_W_L-1:0] pre_q, pre_d;
	logic        cen_q, cen_d;
	logic [7:0]  insel_q, insel_d;
	logic        hsel_q, hsel_d;
	logic        lsel_q, lsel_d;

	// bus decode helpers
	logic        access;               // access phase, before answer
	logic        fire;                 // transfer completes this edge
	logic        wr_gen, wr_sc, rd_res;
	logic        mapped;
	logic [7:0]  res_high, res_low;
	logic [7:0]  ch_dec;
	logic [4:0]  sel_ch;
	logic [PRE_W_L-1:0] pre_last;

	assign access = psel & penable & ~ready_q;
	assign fire   = psel & penable & ready_q;
	assign mapped = (paddr == sar_converter_pkg::GEN_CTRL_ADDR) |
	                (paddr == sar_converter_pkg::STAT_CTRL_ADDR) |
	                (paddr == sar_converter_pkg::RESULT_HIGH_ADDR) |
	                (paddr == sar_converter_pkg::RESULT_LOW_ADDR);
	assign wr_gen = fire & pwrite & (paddr == sar_converter_pkg::GEN_CTRL_ADDR);
	assign wr_sc  = fire & pwrite & (paddr == sar_converter_pkg::STAT_CTRL_ADDR);
	assign rd_res = fire & ~pwrite & ((paddr == sar_converter_pkg::RESULT_HIGH_ADDR) |
	                                  (paddr == sar_converter_pkg::RESULT_LOW_ADDR));

	// result formatting from the latched raw value and current control
	always_comb begin
		res_high = 8'h00;
		res_low  = 8'h00;
		if (gen_q[sar_converter_pkg::EIGHT_BIT_BIT]) begin
			// unsigned: full scale FF, low byte 00
			res_high = raw_q[9:2];
			if (!gen_q[sar_converter_pkg::JUSTIFY_BIT] && gen_q[sar_converter_pkg::SIGNED_BIT]) begin
				res_high[7] = ~raw_q[9];
			end
		end else if (!gen_q[sar_converter_pkg::JUSTIFY_BIT]) begin
			res_high = raw_q[9:2];
			res_low  = {raw_q[1:0], 6'h00};
			if (gen_q[sar_converter_pkg::SIGNED_BIT]) begin
				res_high[7] = ~raw_q[9];
			end
		end else begin
			res_high = {6'h00, raw_q[9:8]};
			res_low  = raw_q[7:0];
		end
	end

	// apb answer: one wait state, registered data and error
	always_comb begin
		// one wait state: ready follows the first access cycle
		ready_d = access;
		err_d   = 1'b0;
		// hold the last word between transfers so prdata stays quiet
		rdata_d = rdata_q;
		if (access) begin
			err_d   = ~mapped;
			rdata_d = 32'h0000_0000;
			unique case (paddr)
				sar_converter_pkg::GEN_CTRL_ADDR:    rdata_d[7:0] = gen_q;
				sar_converter_pkg::STAT_CTRL_ADDR:   rdata_d[7:0] = {flag_q, sc_q};
				sar_converter_pkg::RESULT_HIGH_ADDR: rdata_d[7:0] = res_high;
				sar_converter_pkg::RESULT_LOW_ADDR:  rdata_d[7:0] = res_low;
				default:                             rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// apb registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ready_q <= ready_d;
			err_q   <= err_d;
			rdata_q <= rdata_d;
		end
	end

	// software control state and the done flag
	always_comb begin
		gen_d  = gen_q;
		sc_d   = sc_q;
		flag_d = flag_q;
		raw_d  = raw_q;
		// write sets power-up, reset value zero
		if (wr_gen) begin
			gen_d = pwdata[7:0];
		end
		// flag bit of write data dropped
		if (wr_sc) begin
			sc_d = pwdata[6:0];
		end
		if (wr_sc || rd_res) begin
			flag_d = 1'b0;
		end
		// completion wins over a same-cycle clear so no event is lost
		if (state_q == sar_converter_pkg::ST_CONVERT && sar_done) begin
			flag_d = 1'b1;
			raw_d  = sar_result;
		end
	end

	// control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_q  <= sar_converter_pkg::GEN_CTRL_RESET;
			sc_q   <= sar_converter_pkg::STAT_CTRL_RESET;
			flag_q <= 1'b0;
			raw_q  <= 10'h000;
		end else begin
			gen_q  <= gen_d;
			sc_q   <= sc_d;
			flag_q <= flag_d;
			raw_q  <= raw_d;
		end
	end

	// interrupt level, updated on the same edge as the flag
	always_comb begin
		// level tracks the flag
		// next flag value, so the request moves on the same edge as the flag
		irq_d = flag_d & sc_d[sar_converter_pkg::IRQ_EN_BIT];
	end

	// interrupt flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// channel decode, one bit per input pin
	// code taken from write data, used only on a status write
	assign sel_ch = pwdata[sar_converter_pkg::CHANNEL_MSB:0];
	// references are decoded in the sequencer, not in this loop
	genvar gi;
	generate
		for (gi = 0; gi < sar_converter_pkg::NUM_INPUTS; gi++) begin : g_ch
			assign ch_dec[gi] = (sel_ch == 5'(gi));
		end
	endgenerate

	// prescaler terminal count: 2*(prescale+1)-1
	// even division ratio
	assign pre_last = {gen_q[sar_converter_pkg::PRESCALE_MSB:0], 1'b1};

	// sequencer: start, abort, completion, prescaler
	always_comb begin
		state_d = state_q;
		start_d = 1'b0;
		pre_d   = pre_q;
		cen_d   = 1'b0;
		insel_d = insel_q;
		hsel_d  = hsel_q;
		lsel_d  = lsel_q;
		unique case (state_q)
			sar_converter_pkg::ST_IDLE: begin
				pre_d = '0;
			end
			sar_converter_pkg::ST_CONVERT: begin
				if (pre_q == pre_last) begin
					pre_d = '0;
					cen_d = 1'b1;
				end else begin
					// wraps only through the terminal compare above
					pre_d = pre_q + PRE_W_L'(1);
				end
				if (sar_done) begin
					if (sc_q[sar_converter_pkg::CONT_BIT]) begin
						start_d = 1'b1;
						pre_d   = '0;
						cen_d   = 1'b0;
					end else begin
						// single mode goes idle
						// a last enable may still leave; the idle core ignores it
						state_d = sar_converter_pkg::ST_IDLE;
					end
				end
			end
			default: state_d = sar_converter_pkg::ST_IDLE;
		endcase
		// status write restarts, also aborting a running conversion
		if (wr_sc && gen_q[sar_converter_pkg::POWER_UP_BIT]) begin
			state_d = sar_converter_pkg::ST_CONVERT;
			start_d = 1'b1;
			pre_d   = '0;
			cen_d   = 1'b0;
			insel_d = ch_dec;
			hsel_d  = (sel_ch == sar_converter_pkg::CH_HIGH_REF);
			lsel_d  = (ch_dec == 8'h00) && (sel_ch != sar_converter_pkg::CH_HIGH_REF);
		end
		if (wr_gen || !gen_q[sar_converter_pkg::POWER_UP_BIT]) begin
			state_d = sar_converter_pkg::ST_IDLE;
			start_d = 1'b0;
			cen_d   = 1'b0;
			pre_d   = '0;
		end
	end

	// sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= sar_converter_pkg::ST_IDLE;
			start_q <= 1'b0;
			pre_q   <= '0;
			cen_q   <= 1'b0;
			insel_q <= 8'h00;
			hsel_q  <= 1'b0;
			// low reference out of reset keeps the select one-hot
			lsel_q  <= 1'b1;
		end else begin
			state_q <= state_d;
			start_q <= start_d;
			pre_q   <= pre_d;
			cen_q   <= cen_d;
			insel_q <= insel_d;
			hsel_q  <= hsel_d;
			lsel_q  <= lsel_d;
		end
	end

	// outputs straight from flops
	assign prdata             = rdata_q;
	assign pready             = ready_q;
	assign pslverr            = err_q;
	assign conv_start         = start_q;
	assign conv_clk_en        = cen_q;
	assign converter_power_up = gen_q[sar_converter_pkg::POWER_UP_BIT];
	assign analog_input_sel   = insel_q;
	assign high_reference_sel = hsel_q;
	assign low_reference_sel  = lsel_q;
	assign done_irq           = irq_q;
endmodule : sar_converter_control

// ===== testbench/sar_converter_chk.sv
// port checker for the converter control block
`timescale 1ns/1ps
module sar_converter_chk (
	// clock and reset
	input wire logic	pclk,
	input wire logic	presetn,
	// apb
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata,
	input wire logic	pready,
	input wire logic	pslverr,
	// core side
	input wire logic	sar_done,
	input wire logic [9:0]	sar_result,
	input wire logic	conv_start,
	input wire logic	conv_clk_en,
	input wire logic	converter_power_up,
	input wire logic [7:0]	analog_input_sel,
	input wire logic	high_reference_sel,
	input wire logic	low_reference_sel,
	input wire logic	done_irq
);
	logic	acc;	// completed transfer
	logic	wr_st;	// status write
	logic	wr_gen;	// general control write
	logic	rd_res;	// result byte read
	logic [3:0]	pre_q, pre_d;	// shadow of prescale
	logic [5:0]	gap_q, gap_d;	// cycles since last clock enable
	logic	seen_q, seen_d;	// a pulse seen since start
	assign acc = psel & penable & pready;
	assign wr_st = acc & pwrite & (paddr == sar_converter_pkg::STAT_CTRL_ADDR);
	assign wr_gen = acc & pwrite & (paddr == sar_converter_pkg::GEN_CTRL_ADDR);
	assign rd_res = acc & !pwrite & ((paddr == sar_converter_pkg::RESULT_HIGH_ADDR) |
		(paddr == sar_converter_pkg::RESULT_LOW_ADDR));
	// gap measured only pulse to pulse, so start latency is left free
	always_comb begin
		pre_d = wr_gen ? pwdata[3:0] : pre_q;
		gap_d = conv_clk_en ? 6'h01 : gap_q + 6'h01;
		seen_d = conv_clk_en | (seen_q & !conv_start);
	end
	// helper registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 4'h0;
			gap_q <= 6'h00;
			seen_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			gap_q <= gap_d;
			seen_q <= seen_d;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	stat_start_a: assert property (wr_st && converter_power_up |=> conv_start)
		else $error("no start after status write");
	stat_irq_a: assert property (wr_st && !sar_done |=> !done_irq)
		else $error("irq kept after status write");
	read_clear_a: assert property (rd_res && !sar_done |=> !done_irq)
		else $error("irq kept after result read");
	irq_cause_a: assert property ($rose(done_irq) |-> $past(sar_done))
		else $error("irq rose without completion");
	reset_irq_a: assert property (!$past(presetn) |-> !done_irq)
		else $error("irq pending after reset");
	gen_abort_a: assert property (wr_gen && !sar_done |=> (!conv_start && !conv_clk_en)[*4])
		else $error("activity after general write");
	power_off_a: assert property (!converter_power_up |-> !conv_start && !conv_clk_en)
		else $error("activity while powered down");
	sel_onehot_a: assert property ($onehot({analog_input_sel, high_reference_sel, low_reference_sel}))
		else $error("channel select not one-hot");
	clk_div_a: assert property (conv_clk_en && seen_q |-> gap_q == {1'b0, pre_q, 1'b0} + 6'h02)
		else $error("conversion clock period wrong");
endmodule : sar_converter_chk
bind sar_converter_control sar_converter_chk chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .sar_done, .sar_result, .conv_start, .conv_clk_en,
	.converter_power_up, .analog_input_sel, .high_reference_sel, .low_reference_sel, .done_irq);

// ===== testbench/sar_core_model.sv
// behavioural sar core answering after a few conversion clocks
`timescale 1ns/1ps
module sar_core_model #(
	parameter int NCLK = 3	// conversion clocks per result
) (
	// clock and reset
	input wire logic	pclk,
	input wire logic	presetn,
	// from the block
	input wire logic	conv_start,
	input wire logic	conv_clk_en,
	input wire logic [9:0]	res_in,
	// answer
	output logic	sar_done,
	output logic [9:0]	sar_result
);
	int	cnt_q;	// clocks still to go
	// result valid only in the done cycle, churns otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			sar_done <= 1'b0;
			sar_result <= 10'h000;
		end else begin
			sar_done <= conv_clk_en && cnt_q == 1;
			sar_result <= (conv_clk_en && cnt_q == 1) ? res_in : ~sar_result;
			if (conv_start) cnt_q <= NCLK;
			else if (conv_clk_en && cnt_q > 0) cnt_q <= cnt_q - 1;
		end
	end
endmodule : sar_core_model

// ===== testbench/tb.sv
// testbench of the converter control block
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] A_GEN = sar_converter_pkg::GEN_CTRL_ADDR;
	localparam logic [7:0] A_ST = sar_converter_pkg::STAT_CTRL_ADDR;
	logic	pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]	paddr = 8'h00, analog_input_sel;
	logic [31:0]	pwdata = 32'h0, prdata, rd;
	logic	pready, pslverr, sar_done, conv_start, conv_clk_en, converter_power_up, er;
	logic	high_reference_sel, low_reference_sel, done_irq;
	logic [9:0]	sar_result, xs, res_in = 10'h000;
	int	n_errors = 0, cmp_count = 0, starts = 0, cyc = 0, s0;
	// format table: general bits, input, high:low
	logic [7:0] fmt [8] = '{8'h20, 8'h30, 8'h70, 8'h00, 8'h10, 8'h10, 8'h50, 8'h00};
	logic [9:0] val [8] = '{10'h3FF, 10'h3FF, 10'h000, 10'h3FF, 10'h3FF, 10'h000, 10'h3FF, 10'h2A5};
	logic [15:0] exq [8] = '{16'hFF00, 16'h7F00, 16'h0000, 16'hFFC0, 16'h7FC0, 16'h8000, 16'h03FF, 16'hA940};
	logic [4:0] chs [8] = '{5'h00, 5'h07, 5'h08, 5'h1D, 5'h1E, 5'h1F, 5'h03, 5'h05};
	sar_converter_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sar_done, .sar_result, .conv_start, .conv_clk_en, .converter_power_up,
		.analog_input_sel, .high_reference_sel, .low_reference_sel, .done_irq);
	sar_core_model core (.pclk, .presetn, .conv_start, .conv_clk_en, .res_in, .sar_done, .sar_result);
	initial forever #2 pclk = ~pclk;
	// start counter and hang guard
	always @(posedge pclk) begin
		cyc++;
		if (conv_start === 1'b1) starts++;
		if (cyc == 20000) begin
			n_errors++;
			$display("MISMATCH timeout exp finished got hung at cycle %0d", cyc);
			finish_test();
		end
	end
	task automatic finish_test;
		$display("mismatches %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : cmp
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) begin
			n_errors++;
			$display("MISMATCH pready exp 1 got 0");
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d}, rd, er);
	endtask : wr
	task automatic chk(input string nm, input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 32'h0, rd, er);
		cmp(nm, {24'h0, x}, rd);
	endtask : chk
	task automatic wait_irq;
		int n = 0;
		while (done_irq !== 1'b1 && n < 500) begin
			@(posedge pclk);
			n++;
		end
		cmp("irq", 32'h1, 32'(done_irq));
	endtask : wait_irq
	// software polling, interrupt off
	task automatic poll;
		int n = 0;
		rd = 32'h0;
		while (rd[7] !== 1'b1 && n < 100) begin
			apb(1'b0, A_ST, 32'h0, rd, er);
			n++;
		end
		cmp("poll_flag", 32'h80, rd & 32'h80);
	endtask : poll
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h10, 32'h0, rd, er);
		cmp("unmapped", 32'h1, 32'(er));
		for (int i = 0; i < 8; i++) begin
			wr(A_GEN, 8'h80 | fmt[i] | (i[0] ? 8'h0F : 8'h00));
			res_in <= val[i];
			s0 = starts;
			wr(A_ST, {3'b010, chs[i]});
			wait_irq();
			chk("status", A_ST, {3'b110, chs[i]});
			cmp("irq_hold", 32'h1, 32'(done_irq));
			xs = (chs[i] < 5'h08) ? {8'h01 << chs[i], 2'b00} : (chs[i] == 5'h1E) ? 10'h002 : 10'h001;
			cmp("select", 32'(xs), 32'({analog_input_sel, high_reference_sel, low_reference_sel}));
			chk("high", 8'h08, exq[i][15:8]);
			chk("low", 8'h0C, exq[i][7:0]);
			repeat (40) @(posedge pclk);
			cmp("irq_clr", 32'h0, 32'(done_irq));
			cmp("single", 32'h1, 32'(starts - s0));
		end
		$display("test formats done");
		wr(A_GEN, 8'h80);
		res_in <= 10'h155;
		s0 = starts;
		wr(A_ST, 8'h23);
		poll();
		chk("cont_a", 8'h08, 8'h55);
		res_in <= 10'h2A5;
		chk("cont_b", 8'h0C, 8'h40);
		poll();
		chk("cont_c", 8'h08, 8'hA9);
		cmp("irq_off", 32'h0, 32'(done_irq));
		wr(A_GEN, 8'h00);
		cmp("power_off", 32'h0, 32'(converter_power_up));
		s0 = starts;
		wr(A_ST, 8'hC0);
		chk("ro_flag", A_ST, 8'h40);
		repeat (100) @(posedge pclk);
		cmp("no_start", 32'(s0), 32'(starts));
		$display("test continuous done");
		wr(A_GEN, 8'h80);
		cmp("power_on", 32'h1, 32'(converter_power_up));
		wr(A_ST, 8'h40);
		wait_irq();
		presetn <= 1'b0;
		@(posedge pclk);
		cmp("irq_rst", 32'h0, 32'(done_irq));
		presetn <= 1'b1;
		chk("gen_rst", A_GEN, 8'h00);
		chk("st_rst", A_ST, 8'h00);
		$display("test reset done");
		finish_test();
	end
endmodule : tb
